// file: clkgen_osc.sv
// Purpose: oscillator side model feeding tick pulses
// Assumes: main osc halts while its enable is low
// Notes:   periods set promptness
`timescale 1ns/1ps
module clkgen_osc #(
    parameter int MAIN_PER = 1,
    parameter int SUB_PER  = 8
) (
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    input  wire logic i_main_run,
    output logic      o_main_tick,
    output logic      o_sub_tick
);
    int mc, sc;
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            mc <= 0;
            sc <= 0;
            o_main_tick <= 1'b0;
            o_sub_tick <= 1'b0;
        end else begin
            mc <= (mc + 1) % MAIN_PER;
            sc <= (sc + 1) % SUB_PER;
            o_main_tick <= i_main_run && mc == 0;
            o_sub_tick <= sc == 0;
        end
    end
endmodule

// file: clkgen_pkg.sv
// Purpose: constants for the cpu clock generator and standby control
// Assumes: single system clock, oscillators arrive as enable pulses
// Notes:   register layouts and switch delays in machine cycles
package clkgen_pkg;

    // -------------------------------------------------------------------
    // register layout
    // -------------------------------------------------------------------
    localparam logic [3:0] CPU_CLK_CTRL_RESET = 4'h0;
    localparam logic [3:0] SYS_CLK_CTRL_RESET = 4'h0;
    localparam int         CPU_SEL_LSB        = 0;
    localparam int         HALT_BIT           = 2;
    localparam int         STOP_BIT           = 3;
    localparam int         SUB_SEL_BIT        = 0;
    localparam int         MAIN_OFF_BIT       = 3;

    // -------------------------------------------------------------------
    // cpu clock select codes
    // -------------------------------------------------------------------
    localparam logic [1:0] SEL_DIV64 = 2'h0;
    localparam logic [1:0] SEL_DIV16 = 2'h1;
    localparam logic [1:0] SEL_DIV8  = 2'h2;
    localparam logic [1:0] SEL_DIV4  = 2'h3;

    // -------------------------------------------------------------------
    // main clock dividers and subsystem divider
    // -------------------------------------------------------------------
    localparam logic [11:0] DIV64_MASK = 12'h03F;
    localparam logic [11:0] DIV16_MASK = 12'h00F;
    localparam logic [11:0] DIV8_MASK  = 12'h007;
    localparam logic [11:0] DIV4_MASK  = 12'h003;
    localparam logic [1:0]  SUB_DIV_MASK = 2'h3;

    // -------------------------------------------------------------------
    // switch delay, machine cycles of the old clock
    // -------------------------------------------------------------------
    localparam logic [4:0] SW_DLY_MIN   = 5'h01;
    localparam logic [4:0] SW_DLY_DIV16 = 5'h04;
    localparam logic [4:0] SW_DLY_DIV8  = 5'h08;
    localparam logic [4:0] SW_DLY_MAX   = 5'h10;

    // subsystem cycle time, 4 periods of 32.768 kHz
    localparam real SUB_CYCLE_US = 122.0;

endpackage

// file: clkgen_sva.sv
// Purpose: port checks for the clock generator
// Assumes: one clock, async high reset
// Notes:   bound at the foot
`timescale 1ns/1ps
module clkgen_sva (
    input wire logic        i_sys_clk,
    input wire logic        i_reset,
    input wire logic        i_sub_osc_tick,
    input wire logic        i_cpu_wr,
    input wire logic [3:0]  i_cpu_wdata,
    input wire logic        i_stop_exec,
    input wire logic        i_halt_exec,
    input wire logic        i_standby_release,
    input wire logic [3:0]  o_cpu_clock_ctrl_reg,
    input wire logic [3:0]  o_sys_clock_ctrl_reg,
    input wire logic        o_cpu_clk_en,
    input wire logic        o_cpu_on_sub,
    input wire logic        o_main_osc_enable,
    input wire logic [11:0] o_periph_clk_en,
    input wire logic        o_watch_clk_en,
    input wire logic        o_stop_mode,
    input wire logic        o_halt_mode
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    sequence s_wr;
        i_cpu_wr && !i_stop_exec && !i_halt_exec;
    endsequence
    sequence s_rel;
        i_standby_release && !i_stop_exec && !i_halt_exec;
    endsequence
    a_write_clears_mode: assert property (s_wr |=> o_cpu_clock_ctrl_reg ==
        {2'h0, $past(i_cpu_wdata[1:0])}) else $error("write result wrong");
    a_halt_sets_bit: assert property (i_halt_exec |=> o_halt_mode)
        else $error("halt not entered");
    a_stop_sets_bit: assert property (i_stop_exec && !o_sys_clock_ctrl_reg[0]
        && !o_cpu_on_sub |=> o_stop_mode) else $error("stop not entered");
    a_stop_refused_sub: assert property ((o_cpu_on_sub || o_sys_clock_ctrl_reg[0])
        && !o_stop_mode |=> !o_stop_mode) else $error("stop entered on sub");
    a_release_clears: assert property (s_rel |=> !o_stop_mode && !o_halt_mode)
        else $error("standby not released");
    a_halt_cpu_idle: assert property (o_halt_mode && $past(o_halt_mode)
        |-> !o_cpu_clk_en) else $error("cpu runs in standby");
    a_osc_off_cause: assert property (o_stop_mode || o_sys_clock_ctrl_reg[3]
        |-> !o_main_osc_enable) else $error("main osc not stopped");
    a_main_off_sub: assert property ($rose(o_sys_clock_ctrl_reg[3])
        |-> $past(o_cpu_on_sub)) else $error("main osc stopped off sub");
    a_sub_no_periph: assert property (o_cpu_on_sub && $past(o_cpu_on_sub)
        |-> o_periph_clk_en == 12'h000) else $error("periph clock on sub");
    a_watch_follows: assert property (!$past(i_reset) |->
        o_watch_clk_en == $past(i_sub_osc_tick)) else $error("watch clock wrong");
endmodule
bind cpu_clock_generator_standby clkgen_sva chk (.*);

// file: cpu_clock_generator_standby.sv
// Purpose: cpu clock selection, peripheral clock division, standby control
// Assumes: i_main_osc_tick / i_sub_osc_tick are one-cycle pulses per osc period
// Notes:   clocks leave the block as one-cycle enables on i_sys_clk
//          stop and main-off are the only ways to silence the main oscillator
`timescale 1ns/1ps

module cpu_clock_generator_standby
    import clkgen_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic        i_main_osc_tick,
    input  wire logic        i_sub_osc_tick,
    input  wire logic        i_cpu_wr,
    input  wire logic [3:0]  i_cpu_wdata,
    input  wire logic        i_sys_bit_wr,
    input  wire logic        i_sys_bit_sel,
    input  wire logic        i_sys_bit_val,
    input  wire logic        i_stop_exec,
    input  wire logic        i_halt_exec,
    input  wire logic        i_bank_enable_flag,
    input  wire logic        i_standby_release,
    output logic [3:0]       o_cpu_clock_ctrl_reg,
    output logic [3:0]       o_sys_clock_ctrl_reg,
    output logic             o_cpu_clk_en,
    output logic             o_cpu_on_sub,
    output logic             o_main_osc_enable,
    output logic [11:0]      o_periph_clk_en,
    output logic             o_periph_enable,
    output logic             o_watch_clk_en,
    output logic             o_stop_mode,
    output logic             o_halt_mode
);

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    // all state lives in one struct: one comb copy, one flop copy
    typedef struct packed {
        logic [3:0]  cpu_ctrl;
        logic [3:0]  sys_ctrl;
        logic [1:0]  act_sel;
        logic        act_sub;
        logic [4:0]  sw_cnt;
        logic [11:0] main_div;
        logic [1:0]  sub_div;
        logic        cpu_en;
        logic [11:0] per_en;
        logic        watch_en;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [11:0] sel_mask;
    logic        main_tick;
    logic        cyc_tick;
    logic        cur_sub;
    logic        cur_halt;
    logic [11:0] per_tick;

    // bank enable only steers data addressing; standby never looks at it
    logic        unused_bank;
    assign unused_bank = i_bank_enable_flag;

    // main oscillator ticks vanish once its generation is terminated
    assign main_tick = i_main_osc_tick & ~s_q.sys_ctrl[MAIN_OFF_BIT];

    // -------------------------------------------------------------------
    // peripheral taps
    // -------------------------------------------------------------------
    // tap n fires on the main tick that closes 2^(n+1) main periods;
    // taps go quiet on the subsystem clock, where main may be switched off
    for (genvar g = 0; g < 12; g++) begin : g_per_tap
        assign per_tick[g] = main_tick & (&s_q.main_div[g:0]) & ~s_q.act_sub;
    end

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // sel_mask holds the divider taps that close one machine cycle on main
        case (s_q.act_sel)
            SEL_DIV64: sel_mask = DIV64_MASK;
            SEL_DIV16: sel_mask = DIV16_MASK;
            SEL_DIV8:  sel_mask = DIV8_MASK;
            SEL_DIV4:  sel_mask = DIV4_MASK;
            default:   sel_mask = DIV64_MASK;
        endcase
        cur_sub  = s_q.act_sub;
        cur_halt = s_q.cpu_ctrl[HALT_BIT];
        cyc_tick = 1'h0;

        // divider chain on the main oscillator
        if (main_tick) begin
            s_d.main_div = s_q.main_div + 12'h001;
        end
        // the subsystem divider has no off switch: cpu on sub needs it; watch uses the raw sub tick
        if (i_sub_osc_tick) begin
            s_d.sub_div = s_q.sub_div + 2'h1;
        end

        // machine cycle of the clock actually in use
        if (cur_sub) begin
            cyc_tick = i_sub_osc_tick && (s_q.sub_div == SUB_DIV_MASK);
        end else begin
            cyc_tick = main_tick && ((s_q.main_div & sel_mask) == sel_mask);
        end
        // stop freezes the cpu and main oscillator, halt freezes the cpu only
        s_d.cpu_en = cyc_tick & ~cur_halt & ~s_q.cpu_ctrl[STOP_BIT];

        // peripheral clocks: bit n is main/2^(n+1); dead on subsystem
        s_d.per_en   = per_tick;
        s_d.watch_en = i_sub_osc_tick;

        // pending clock change: old clock kept for a number of cycles
        // both selects move on a machine cycle edge of the old clock; the new
        // clock's divider is not restarted, so its first cycle can be a runt
        if ((s_q.cpu_ctrl[1:0] != s_q.act_sel) || (s_q.sys_ctrl[SUB_SEL_BIT] != s_q.act_sub)) begin
            if (cyc_tick) begin
                if (s_q.sw_cnt <= SW_DLY_MIN) begin
                    s_d.act_sel = s_q.cpu_ctrl[1:0];
                    s_d.act_sub = s_q.sys_ctrl[SUB_SEL_BIT];
                    s_d.sw_cnt  = SW_DLY_MAX;
                end else begin
                    s_d.sw_cnt = s_q.sw_cnt - 5'h01;
                end
            end
        end else begin
            // old setting decides the wait: slower clocks need fewer cycles
            case (s_q.act_sel)
                SEL_DIV64: s_d.sw_cnt = SW_DLY_MIN;
                SEL_DIV16: s_d.sw_cnt = SW_DLY_DIV16;
                SEL_DIV8:  s_d.sw_cnt = SW_DLY_DIV8;
                SEL_DIV4:  s_d.sw_cnt = SW_DLY_MAX;
                default:   s_d.sw_cnt = SW_DLY_MIN;
            endcase
            if (s_q.act_sub) begin
                s_d.sw_cnt = SW_DLY_MIN;
            end
        end

        // processor clock control register
        // a write never sets the standby bits; only the instructions do
        if (i_cpu_wr) begin
            s_d.cpu_ctrl = {2'h0, i_cpu_wdata[1:0]};
        end
        if (i_halt_exec) begin
            s_d.cpu_ctrl[HALT_BIT] = 1'h1;
        end
        // stop would kill the main oscillator, so it is refused once the
        // subsystem clock is in use or already selected
        if (i_stop_exec && !cur_sub && !s_q.sys_ctrl[SUB_SEL_BIT]) begin
            s_d.cpu_ctrl[STOP_BIT] = 1'h1;
        end
        // release wins over a write, loses to a new standby instruction
        if (i_standby_release && !i_stop_exec && !i_halt_exec) begin
            s_d.cpu_ctrl[HALT_BIT] = 1'h0;
            s_d.cpu_ctrl[STOP_BIT] = 1'h0;
        end

        // system clock control: one bit per manipulation
        // main-off may only be set while the cpu already runs on the
        // subsystem clock; clearing it is always allowed
        if (i_sys_bit_wr) begin
            if (!i_sys_bit_sel) begin
                s_d.sys_ctrl[SUB_SEL_BIT] = i_sys_bit_val;
            end else if (!i_sys_bit_val || cur_sub) begin
                s_d.sys_ctrl[MAIN_OFF_BIT] = i_sys_bit_val;
            end
        end
    end

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            // clear the whole struct, then the fields with named resets
            s_q          <= '0;
            s_q.cpu_ctrl <= CPU_CLK_CTRL_RESET;
            s_q.sys_ctrl <= SYS_CLK_CTRL_RESET;
            s_q.act_sel  <= SEL_DIV64;
            s_q.sw_cnt   <= SW_DLY_MIN;
        end else begin
            s_q <= s_d;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign o_cpu_clock_ctrl_reg = s_q.cpu_ctrl;
    assign o_sys_clock_ctrl_reg = s_q.sys_ctrl;
    assign o_cpu_clk_en         = s_q.cpu_en;
    assign o_cpu_on_sub         = s_q.act_sub;
    // oscillator enable is decoded from flops only, so it cannot glitch
    assign o_main_osc_enable    = ~s_q.sys_ctrl[MAIN_OFF_BIT] & ~s_q.cpu_ctrl[STOP_BIT];
    assign o_periph_clk_en      = s_q.per_en;
    // peripherals lose their clock source once the cpu is on the subsystem
    assign o_periph_enable      = ~s_q.act_sub;
    assign o_watch_clk_en       = s_q.watch_en;
    assign o_stop_mode          = s_q.cpu_ctrl[STOP_BIT];
    assign o_halt_mode          = s_q.cpu_ctrl[HALT_BIT];

endmodule

// file: tb_cpu_clock_generator_standby.sv
// Purpose: random and corner tests of the clock generator
// Assumes: main tick every cycle, sub tick every 8
// Notes:   settles 18 machine cycles after each divider switch, 20 after each sub switch
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
    $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb_cpu_clock_generator_standby;
    import clkgen_pkg::*;
    logic i_sys_clk = 0, i_reset = 1, i_main_osc_tick, i_sub_osc_tick, i_cpu_wr, i_sys_bit_wr;
    logic i_sys_bit_sel, i_sys_bit_val, i_stop_exec, i_halt_exec, i_bank_enable_flag;
    logic i_standby_release, o_cpu_clk_en, o_cpu_on_sub, o_main_osc_enable, o_periph_enable;
    logic o_watch_clk_en, o_stop_mode, o_halt_mode;
    logic [3:0] i_cpu_wdata, o_cpu_clock_ctrl_reg, o_sys_clock_ctrl_reg, d;
    logic [11:0] o_periph_clk_en;
    logic [1:0] p;
    int seed = 32'hbf98b9bf, fails = 0, comparisons = 0, n, k;
    cpu_clock_generator_standby uut (.*);
    clkgen_osc osc (.i_sys_clk, .i_reset, .i_main_run(o_main_osc_enable),
        .o_main_tick(i_main_osc_tick), .o_sub_tick(i_sub_osc_tick));
    always #2.5 i_sys_clk = ~i_sys_clk;
    task step; @(posedge i_sys_clk); #1; endtask
    task automatic pulse(ref logic s); s = 1; step; s = 0; endtask
    task sbit(input logic s, v);
        i_sys_bit_sel = s;
        i_sys_bit_val = v;
        pulse(i_sys_bit_wr);
        step;
    endtask
    function int gap_of(logic [1:0] s);
        return s == SEL_DIV64 ? 64 : s == SEL_DIV16 ? 16 : s == SEL_DIV8 ? 8 : 4;
    endfunction
    task close_out;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task wait_en(output int g);
        g = 0;
        do begin step; g++; end while (o_cpu_clk_en !== 1'b1 && g < 600);
        if (g >= 600) begin fails++; close_out; end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {i_cpu_wr, i_cpu_wdata, i_sys_bit_wr, i_sys_bit_sel, i_sys_bit_val} = '0;
        {i_stop_exec, i_halt_exec, i_bank_enable_flag, i_standby_release} = '0;
        repeat (12) @(posedge i_sys_clk);
        #1 i_reset = 0;
        `CHK("pcc", 4'h0, o_cpu_clock_ctrl_reg)
        `CHK("scc", 4'h0, o_sys_clock_ctrl_reg)
        wait_en(n);
        wait_en(n);
        `CHK("gap", 64, n)
        sbit(1, 1);
        `CHK("scc", 4'h0, o_sys_clock_ctrl_reg)
        p = SEL_DIV64;
        for (int i = 0; i < 8; i++) begin
            d = 4'($random(seed));
            if (i < 4) d[1:0] = i[1:0];
            i_cpu_wdata = d;
            pulse(i_cpu_wr);
            `CHK("pcc", {2'h0, d[1:0]}, o_cpu_clock_ctrl_reg)
            repeat (2) wait_en(n);
            if (p != SEL_DIV64) `CHK("old", gap_of(p), n)
            repeat (16) wait_en(n);
            `CHK("gap", gap_of(d[1:0]), n)
            p = d[1:0];
        end
        for (int b = 0; b < 2; b++) begin
            i_bank_enable_flag = b[0];
            pulse(i_halt_exec);
            step;
            `CHK("halt", 1'b1, o_halt_mode)
            k = 0;
            repeat (100) begin step; k += int'(o_cpu_clk_en !== 1'b0); end
            `CHK("idle", 0, k)
            pulse(i_standby_release);
            `CHK("halt", 1'b0, o_halt_mode)
            pulse(i_stop_exec);
            step;
            `CHK("stop", 1'b1, o_stop_mode)
            `CHK("osc", 1'b0, o_main_osc_enable)
            pulse(i_standby_release);
            `CHK("stop", 1'b0, o_stop_mode)
            `CHK("osc", 1'b1, o_main_osc_enable)
        end
        i_cpu_wdata = {2'h0, SEL_DIV4};
        pulse(i_cpu_wr);
        sbit(0, 1);
        repeat (20) wait_en(n);
        `CHK("sub", 1'b1, o_cpu_on_sub)
        `CHK("gap", 32, n)
        `CHK("per", 12'h000, o_periph_clk_en)
        `CHK("pen", 1'b0, o_periph_enable)
        k = 0;
        repeat (64) begin step; k += o_watch_clk_en; end
        `CHK("watch", 8, k)
        pulse(i_stop_exec);
        step;
        `CHK("stop", 1'b0, o_stop_mode)
        pulse(i_halt_exec);
        step;
        `CHK("halt", 1'b1, o_halt_mode)
        pulse(i_standby_release);
        sbit(1, 1);
        `CHK("osc", 1'b0, o_main_osc_enable)
        repeat (2) wait_en(n);
        `CHK("gap", 32, n)
        sbit(1, 0);
        sbit(0, 0);
        repeat (20) wait_en(n);
        `CHK("sub", 1'b0, o_cpu_on_sub)
        `CHK("gap", 4, n)
        `CHK("pen", 1'b1, o_periph_enable)
        k = 0;
        repeat (64) begin step; k += int'(o_periph_clk_en[2] === 1'b1); end
        `CHK("per", 8, k)
        close_out;
    end
endmodule
